// ==== hw/sqs_pkg.sv ====
// Constants and types shared by the sequence switch block
package sqs_pkg;

    // -------------------------------------------------------------
    // Register byte offsets
    // -------------------------------------------------------------
    localparam logic [7:0] OFS_SWITCH_WORD = 8'h00;
    localparam logic [7:0] OFS_ACTIVE_WORD = 8'h04;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
    localparam logic [7:0] OFS_SEQ_STATE = 8'h10;

    // -------------------------------------------------------------
    // Switch word fields
    // -------------------------------------------------------------
    localparam int BIT_SERVO_IGNORE = 0;
    localparam int BIT_ABS_IGNORE = 1;
    localparam int BIT_FWD_IGNORE = 2;
    localparam int BIT_REV_IGNORE = 3;
    localparam int BIT_ROT_TORQUE = 4;
    localparam int BIT_PWR_AUTORESET = 5;
    localparam int BIT_ALM_COAST = 6;
    localparam int BIT_ALM_KEEP_DB = 7;
    localparam int BIT_OT_EMG_DECEL = 8;
    localparam int BIT_OT_ZCLAMP = 9;
    localparam int POS_CTL_MODE = 10;
    localparam int POS_MSW_SEL = 12;
    localparam logic [15:0] SWITCH_WORD_RESET = 16'h0080;

    // -------------------------------------------------------------
    // Interrupt status bits
    // -------------------------------------------------------------
    localparam int EVT_ALARM = 0;
    localparam int EVT_OVERTRAVEL = 1;
    localparam int EVT_PWR_RECOVER = 2;
    localparam int EVT_MODE_SWITCH = 3;
    localparam int EVT_COUNT = 4;

    // -------------------------------------------------------------
    // Enumerations
    // -------------------------------------------------------------
    typedef enum logic [1:0] {
        CTL_SPEED = 2'b00,
        CTL_SPEED_ZCLAMP = 2'b01,
        CTL_TORQUE_I = 2'b10,
        CTL_TORQUE_II = 2'b11
    } sqs_ctl_mode_t;

    typedef enum logic [1:0] {
        MSW_TORQUE = 2'b00,
        MSW_SPEED = 2'b01,
        MSW_ACCEL = 2'b10,
        MSW_OFF = 2'b11
    } sqs_msw_sel_t;

    typedef enum logic [2:0] {
        SEQ_OFF = 3'b000,
        SEQ_RUN = 3'b001,
        SEQ_ALM_STOP = 3'b010,
        SEQ_ALM_HOLD = 3'b011,
        SEQ_OT_DECEL = 3'b100,
        SEQ_OT_HOLD = 3'b101,
        SEQ_OT_STOP = 3'b110
    } sqs_seq_t;

endpackage

// ==== hw/sqs_switch.sv ====
// Sequence switch word, stop sequences and AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none

module sqs_switch (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Contact inputs from the host controller
    input wire logic servo_on_input,
    input wire logic absolute_data_request_input,
    input wire logic forward_travel_block_input,
    input wire logic reverse_travel_block_input,
    input wire logic alarm_reset_input,
    // Drive status
    input wire logic drive_power_restart,
    input wire logic alarm_detect,
    input wire logic power_loss,
    input wire logic motor_running,
    input wire logic motor_stopped,
    input wire logic torque_limit_active,
    input wire logic torque_ref_over_level,
    input wire logic speed_ref_over_level,
    input wire logic accel_over_level,
    // Sequence outputs
    output logic rotation_detect_output,
    output logic servo_enable,
    output logic dynamic_brake,
    output logic emg_stop_torque_decel,
    output logic zero_clamp,
    output logic forward_permit,
    output logic reverse_permit,
    output logic [1:0] control_mode,
    output logic mode_switch_active,
    output logic irq
);

    typedef struct packed {
        logic [15:0] word;
        logic [15:0] active;
        logic loaded;
        sqs_pkg::sqs_seq_t seq;
        logic alarm;
        logic pwr_lost;
        logic [sqs_pkg::EVT_COUNT-1:0] status;
        logic [sqs_pkg::EVT_COUNT-1:0] mask;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
        logic irq;
        logic rot;
        logic servo;
        logic brake;
        logic emg;
        logic zclamp;
        logic fwd_ok;
        logic rev_ok;
        logic [1:0] mode;
        logic msw;
    } sqs_state_t;

    localparam sqs_state_t STATE_RESET = '{
        word: sqs_pkg::SWITCH_WORD_RESET,
        active: sqs_pkg::SWITCH_WORD_RESET,
        loaded: 1'b0,
        seq: sqs_pkg::SEQ_OFF,
        alarm: 1'b0,
        pwr_lost: 1'b0,
        status: '0,
        mask: '0,
        wr_pend: 1'b0,
        wr_addr: 8'h00,
        rdata: 32'h0000_0000,
        irq: 1'b0,
        rot: 1'b0,
        servo: 1'b0,
        brake: 1'b0,
        emg: 1'b0,
        zclamp: 1'b0,
        fwd_ok: 1'b0,
        rev_ok: 1'b0,
        mode: 2'b00,
        msw: 1'b0
    };

    sqs_state_t r;
    sqs_state_t next_r;

    function automatic logic [31:0] read_mux(input sqs_state_t s, input logic [7:0] a);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (a)
            sqs_pkg::OFS_SWITCH_WORD: d = {16'h0000, s.word};
            sqs_pkg::OFS_ACTIVE_WORD: d = {16'h0000, s.active};
            sqs_pkg::OFS_IRQ_STATUS: d = {28'h0000000, s.status};
            sqs_pkg::OFS_IRQ_MASK: d = {28'h0000000, s.mask};
            sqs_pkg::OFS_SEQ_STATE: d = {24'h000000, s.alarm, s.seq, s.mode, s.msw, s.loaded};
            default: d = 32'h0000_0000;
        endcase
        return d;
    endfunction

    // -------------------------------------------------------------
    // Next-state logic
    // -------------------------------------------------------------
    logic [15:0] cfg;
    logic servo_req;
    logic abs_ok;
    logic fwd_block;
    logic rev_block;
    logic ready;
    logic ot;
    logic addr_take;
    logic [sqs_pkg::EVT_COUNT-1:0] evt;
    logic [sqs_pkg::EVT_COUNT-1:0] w1c;

    always_comb
    begin
        next_r = r;
        cfg = r.active;
        evt = '0;
        w1c = '0;
        servo_req = cfg[sqs_pkg::BIT_SERVO_IGNORE] | servo_on_input;
        abs_ok = cfg[sqs_pkg::BIT_ABS_IGNORE] | absolute_data_request_input;
        fwd_block = ~cfg[sqs_pkg::BIT_FWD_IGNORE] & forward_travel_block_input;
        rev_block = ~cfg[sqs_pkg::BIT_REV_IGNORE] & reverse_travel_block_input;
        ready = servo_req & abs_ok;
        ot = fwd_block | rev_block;

        // Only the first load after reset or a drive power restart moves the written word into use
        if (!r.loaded || drive_power_restart)
        begin
            next_r.active = r.word;
            next_r.loaded = 1'b1;
        end

        // Alarm latch; power loss counts as an alarm
        next_r.pwr_lost = power_loss;
        if (alarm_reset_input && !alarm_detect && !power_loss)
            next_r.alarm = 1'b0;
        if (r.pwr_lost && !power_loss)
        begin
            evt[sqs_pkg::EVT_PWR_RECOVER] = 1'b1;
            if (cfg[sqs_pkg::BIT_PWR_AUTORESET] && !alarm_detect)
                next_r.alarm = 1'b0;
        end
        if (alarm_detect || power_loss)
            next_r.alarm = 1'b1;
        evt[sqs_pkg::EVT_ALARM] = next_r.alarm & ~r.alarm;

        // Stop sequences; alarm outranks loss of servo request, which outranks overtravel
        case (r.seq)
            sqs_pkg::SEQ_OFF:
                if (next_r.alarm)
                    next_r.seq = sqs_pkg::SEQ_ALM_STOP;
                else if (ready && !ot)
                    next_r.seq = sqs_pkg::SEQ_RUN;
            sqs_pkg::SEQ_RUN:
                if (next_r.alarm)
                    next_r.seq = sqs_pkg::SEQ_ALM_STOP;
                else if (!ready)
                    next_r.seq = sqs_pkg::SEQ_OFF;
                else if (ot)
                begin
                    evt[sqs_pkg::EVT_OVERTRAVEL] = 1'b1;
                    if (cfg[sqs_pkg::BIT_OT_EMG_DECEL])
                        next_r.seq = sqs_pkg::SEQ_OT_DECEL;
                    else
                        next_r.seq = sqs_pkg::SEQ_OT_STOP;
                end
            sqs_pkg::SEQ_ALM_STOP:
                if (!next_r.alarm)
                    next_r.seq = sqs_pkg::SEQ_OFF;
                else if (motor_stopped)
                    next_r.seq = sqs_pkg::SEQ_ALM_HOLD;
            sqs_pkg::SEQ_ALM_HOLD:
                if (!next_r.alarm)
                    next_r.seq = sqs_pkg::SEQ_OFF;
            sqs_pkg::SEQ_OT_DECEL:
                if (next_r.alarm)
                    next_r.seq = sqs_pkg::SEQ_ALM_STOP;
                else if (!ready)
                    next_r.seq = sqs_pkg::SEQ_OFF;
                else if (motor_stopped)
                    next_r.seq = sqs_pkg::SEQ_OT_HOLD;
            sqs_pkg::SEQ_OT_HOLD, sqs_pkg::SEQ_OT_STOP:
                if (next_r.alarm)
                    next_r.seq = sqs_pkg::SEQ_ALM_STOP;
                else if (!ready)
                    next_r.seq = sqs_pkg::SEQ_OFF;
                else if (!ot)
                    next_r.seq = sqs_pkg::SEQ_RUN;
            default:
                next_r.seq = sqs_pkg::SEQ_OFF;
        endcase

        // Registered sequence outputs; servo, emg, zclamp and brake decoded from the next state
        next_r.servo = (next_r.seq == sqs_pkg::SEQ_RUN) || (next_r.seq == sqs_pkg::SEQ_OT_DECEL)
            || ((next_r.seq == sqs_pkg::SEQ_OT_HOLD) && cfg[sqs_pkg::BIT_OT_ZCLAMP]);
        next_r.emg = next_r.seq == sqs_pkg::SEQ_OT_DECEL;
        next_r.zclamp = (next_r.seq == sqs_pkg::SEQ_OT_HOLD) && cfg[sqs_pkg::BIT_OT_ZCLAMP];
        next_r.brake = !cfg[sqs_pkg::BIT_ALM_COAST]
            && ((next_r.seq == sqs_pkg::SEQ_ALM_STOP) || (next_r.seq == sqs_pkg::SEQ_OT_STOP)
            || ((next_r.seq == sqs_pkg::SEQ_ALM_HOLD) && cfg[sqs_pkg::BIT_ALM_KEEP_DB]));
        next_r.fwd_ok = ~fwd_block;
        next_r.rev_ok = ~rev_block;
        next_r.rot = cfg[sqs_pkg::BIT_ROT_TORQUE] ? torque_limit_active : motor_running;
        next_r.mode = cfg[sqs_pkg::POS_CTL_MODE +: 2];
        case (sqs_pkg::sqs_msw_sel_t'(cfg[sqs_pkg::POS_MSW_SEL +: 2]))
            sqs_pkg::MSW_TORQUE: next_r.msw = torque_ref_over_level;
            sqs_pkg::MSW_SPEED: next_r.msw = speed_ref_over_level;
            sqs_pkg::MSW_ACCEL: next_r.msw = accel_over_level;
            default: next_r.msw = 1'b0;
        endcase
        evt[sqs_pkg::EVT_MODE_SWITCH] = next_r.msw & ~r.msw;

        // Bus data phase: write lands one cycle after its address phase
        if (r.wr_pend)
        begin
            case (r.wr_addr)
                sqs_pkg::OFS_SWITCH_WORD: next_r.word = hwdata[15:0];
                sqs_pkg::OFS_IRQ_STATUS: w1c = hwdata[sqs_pkg::EVT_COUNT-1:0];
                sqs_pkg::OFS_IRQ_MASK: next_r.mask = hwdata[sqs_pkg::EVT_COUNT-1:0];
                default: w1c = '0;
            endcase
        end
        // A new event beats a same-cycle clear
        next_r.status = (r.status & ~w1c) | evt;
        next_r.irq = |(next_r.status & next_r.mask);

        addr_take = hsel && hready && htrans[1];
        next_r.wr_pend = addr_take && hwrite;
        next_r.wr_addr = haddr;
        next_r.rdata = (addr_take && !hwrite) ? read_mux(next_r, haddr) : 32'h0000_0000;
    end

    // -------------------------------------------------------------
    // State register
    // -------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            r <= STATE_RESET;
        else
            r <= next_r;
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = r.rdata;
    assign rotation_detect_output = r.rot;
    assign servo_enable = r.servo;
    assign dynamic_brake = r.brake;
    assign emg_stop_torque_decel = r.emg;
    assign zero_clamp = r.zclamp;
    assign forward_permit = r.fwd_ok;
    assign reverse_permit = r.rev_ok;
    assign control_mode = r.mode;
    assign mode_switch_active = r.msw;
    assign irq = r.irq;

    // -------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_servo_ignore: assert property (r.active[sqs_pkg::BIT_SERVO_IGNORE] && !r.alarm
        && !alarm_detect && !power_loss && !ot
        && (r.active[sqs_pkg::BIT_ABS_IGNORE] || absolute_data_request_input)
        && r.seq == sqs_pkg::SEQ_OFF |=> r.servo)
        else $error("servo not enabled with servo-on ignored");
    a_abs_block: assert property (!r.active[sqs_pkg::BIT_ABS_IGNORE]
        && !absolute_data_request_input && r.seq == sqs_pkg::SEQ_OFF |=> !r.servo)
        else $error("servo enabled without absolute data request");
    a_fwd_permit: assert property (resetn |=> r.fwd_ok ==
        ($past(r.active[sqs_pkg::BIT_FWD_IGNORE]) || !$past(forward_travel_block_input)))
        else $error("forward permit wrong");
    a_rot_select: assert property (r.active[sqs_pkg::BIT_ROT_TORQUE] && $stable(r.active)
        |=> r.rot == $past(torque_limit_active))
        else $error("rotation detect not torque limit");
    a_pwr_reset: assert property (r.active[sqs_pkg::BIT_PWR_AUTORESET] && r.pwr_lost
        && !power_loss && !alarm_detect |=> !r.alarm)
        else $error("alarm kept after power recovery");
    a_alarm_brake: assert property ($rose(r.alarm) && !r.active[sqs_pkg::BIT_ALM_COAST]
        |-> r.brake || r.seq != sqs_pkg::SEQ_ALM_STOP)
        else $error("no dynamic brake at alarm stop");
    a_brake_hold: assert property (r.seq == sqs_pkg::SEQ_ALM_HOLD
        |-> r.brake == (!r.active[sqs_pkg::BIT_ALM_COAST] && r.active[sqs_pkg::BIT_ALM_KEEP_DB]))
        else $error("dynamic brake hold wrong");
    a_ot_decel: assert property (r.seq == sqs_pkg::SEQ_RUN && ot && ready && !alarm_detect
        && !power_loss && !r.alarm && r.active[sqs_pkg::BIT_OT_EMG_DECEL] |=> r.emg && r.servo)
        else $error("overtravel did not decelerate");
    a_ot_clamp: assert property (r.seq == sqs_pkg::SEQ_OT_HOLD
        |-> r.zclamp == r.active[sqs_pkg::BIT_OT_ZCLAMP] && r.servo == r.zclamp)
        else $error("overtravel hold wrong");
    a_mode_out: assert property ($stable(r.active) [*2] |-> r.mode == r.active[11:10])
        else $error("control mode mismatch");
    a_msw_off: assert property (r.active[13:12] == 2'b11 |=> !r.msw)
        else $error("mode switch active while disabled");
    a_word_held: assert property (r.loaded && !drive_power_restart |=> $stable(r.active))
        else $error("switch word changed without power cycle");

    c_alarm_hold: cover property (r.seq == sqs_pkg::SEQ_ALM_STOP ##1 r.seq == sqs_pkg::SEQ_ALM_HOLD);
    c_ot_clamp: cover property (r.seq == sqs_pkg::SEQ_OT_DECEL ##1 r.zclamp);
    c_reload: cover property (drive_power_restart && r.word != r.active);
    c_irq: cover property ($rose(r.irq));

endmodule

`default_nettype wire

// ==== test/sqs_host_model.sv ====
// Host controller model that drives the drive's contact inputs
`timescale 1ns/1ps
`default_nettype none

module sqs_host_model (
    // Clock
    input wire logic clk,
    // Contact outputs
    output logic servo_on_input,
    output logic absolute_data_request_input,
    output logic forward_travel_block_input,
    output logic reverse_travel_block_input,
    output logic alarm_reset_input
);
    // -------------------------------------------------------------
    // Contact levels
    // -------------------------------------------------------------
    // Order: servo on, abs request, forward block, reverse block, alarm reset
    task automatic apply_now(input logic [4:0] c);
        servo_on_input = c[4];
        absolute_data_request_input = c[3];
        forward_travel_block_input = c[2];
        reverse_travel_block_input = c[1];
        alarm_reset_input = c[0];
    endtask

    // Contacts only change just after an edge, like a real controller output card
    task automatic apply(input logic [4:0] c);
        @(posedge clk);
        servo_on_input <= c[4];
        absolute_data_request_input <= c[3];
        forward_travel_block_input <= c[2];
        reverse_travel_block_input <= c[1];
        alarm_reset_input <= c[0];
    endtask
endmodule

`default_nettype wire

// ==== test/tb.sv ====
// Self-checking testbench for the sequence switch block
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic clk, resetn, hsel, hwrite, hreadyout, hresp, drive_power_restart;
    logic alarm_detect, power_loss, motor_running, motor_stopped, torque_limit_active;
    logic torque_ref_over_level, speed_ref_over_level, accel_over_level;
    logic servo_on_input, absolute_data_request_input, forward_travel_block_input;
    logic reverse_travel_block_input, alarm_reset_input;
    logic rotation_detect_output, servo_enable, dynamic_brake, emg_stop_torque_decel;
    logic zero_clamp, forward_permit, reverse_permit, mode_switch_active, irq;
    logic [1:0] htrans, control_mode;
    logic [2:0] hsize;
    logic [7:0] haddr;
    logic [31:0] hwdata, hrdata, rd;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;

    sqs_switch u_dut (
        .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .servo_on_input(servo_on_input),
        .absolute_data_request_input(absolute_data_request_input),
        .forward_travel_block_input(forward_travel_block_input),
        .reverse_travel_block_input(reverse_travel_block_input),
        .alarm_reset_input(alarm_reset_input), .drive_power_restart(drive_power_restart),
        .alarm_detect(alarm_detect), .power_loss(power_loss), .motor_running(motor_running),
        .motor_stopped(motor_stopped), .torque_limit_active(torque_limit_active),
        .torque_ref_over_level(torque_ref_over_level),
        .speed_ref_over_level(speed_ref_over_level), .accel_over_level(accel_over_level),
        .rotation_detect_output(rotation_detect_output), .servo_enable(servo_enable),
        .dynamic_brake(dynamic_brake), .emg_stop_torque_decel(emg_stop_torque_decel),
        .zero_clamp(zero_clamp), .forward_permit(forward_permit),
        .reverse_permit(reverse_permit), .control_mode(control_mode),
        .mode_switch_active(mode_switch_active), .irq(irq)
    );

    sqs_host_model u_host (
        .clk(clk), .servo_on_input(servo_on_input),
        .absolute_data_request_input(absolute_data_request_input),
        .forward_travel_block_input(forward_travel_block_input),
        .reverse_travel_block_input(reverse_travel_block_input),
        .alarm_reset_input(alarm_reset_input)
    );

    always #12.5 clk = ~clk;

    // -------------------------------------------------------------
    // Tasks
    // -------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // One single-word transfer; the wait relies on the global timeout
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Order: alarm, power loss, running, stopped, torque limit, torque/speed/accel levels
    task automatic status(input logic [7:0] s);
        @(posedge clk);
        alarm_detect <= s[7];
        power_loss <= s[6];
        motor_running <= s[5];
        motor_stopped <= s[4];
        torque_limit_active <= s[3];
        torque_ref_over_level <= s[2];
        speed_ref_over_level <= s[1];
        accel_over_level <= s[0];
    endtask

    // Written word only counts after a power cycle
    task automatic load_word(input logic [31:0] w);
        bus(1'b1, sqs_pkg::OFS_SWITCH_WORD, w);
        @(posedge clk);
        drive_power_restart <= 1'b1;
        @(posedge clk);
        drive_power_restart <= 1'b0;
        settle(3);
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end

    // -------------------------------------------------------------
    // Sequence
    // -------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        resetn = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata, drive_power_restart} = '0;
        hsize = 3'b010;
        u_host.apply_now(5'h00);
        status(8'h00);
        repeat (9) @(posedge clk);
        resetn <= 1'b1;
        bus(1'b0, sqs_pkg::OFS_SWITCH_WORD, 32'h0);
        check("switch word reset", rd, 32'h0000_0080);
        bus(1'b0, sqs_pkg::OFS_ACTIVE_WORD, 32'h0);
        check("active word reset", rd, 32'h0000_0080);
        bus(1'b0, 8'h40, 32'h0);
        check("unmapped read", rd, 32'h0);
        bus(1'b1, sqs_pkg::OFS_SWITCH_WORD, 32'h0000_0c00);
        settle(3);
        check("mode before restart", {30'h0, control_mode}, 32'h0);
        bus(1'b0, sqs_pkg::OFS_ACTIVE_WORD, 32'h0);
        check("active before restart", rd, 32'h0000_0080);
        for (int m = 0; m < 4; m++)
        begin
            load_word(32'(m) << 10);
            check("control mode", {30'h0, control_mode}, 32'(m));
        end
        for (int s = 0; s < 4; s++)
        begin
            load_word(32'(s) << 12);
            for (int c = 0; c < 3; c++)
            begin
                status(8'h04 >> c);
                settle(3);
                check("mode switch", {31'h0, mode_switch_active}, 32'(s == c));
            end
            status(8'h00);
        end
        load_word(32'h0000_0003);
        settle(3);
        check("servo forced on", {31'h0, servo_enable}, 32'h1);
        load_word(32'h0000_0000);
        u_host.apply(5'b10000);
        settle(3);
        check("servo waits abs", {31'h0, servo_enable}, 32'h0);
        u_host.apply(5'b11000);
        settle(3);
        check("servo on input", {31'h0, servo_enable}, 32'h1);
        u_host.apply(5'b11100);
        settle(3);
        check("fwd blocked", {30'h0, forward_permit, reverse_permit}, 32'h1);
        check("ot stop", {30'h0, servo_enable, dynamic_brake}, 32'h1);
        load_word(32'h0000_000c);
        u_host.apply(5'b11110);
        settle(4);
        check("blocks ignored", {30'h0, forward_permit, reverse_permit}, 32'h3);
        for (int b = 0; b < 2; b++)
        begin
            load_word(32'h0000_0100 | (32'(b) << 9));
            check("both blocked", {30'h0, forward_permit, reverse_permit}, b ? 32'h3 : 32'h0);
            u_host.apply(5'b11000);
            settle(3);
            u_host.apply(5'b11100);
            settle(3);
            check("emg decel", {31'h0, emg_stop_torque_decel}, 32'h1);
            status(8'h10);
            settle(3);
            check("ot hold", {30'h0, zero_clamp, servo_enable}, b ? 32'h3 : 32'h0);
            u_host.apply(5'b11000);
            status(8'h00);
        end
        for (int b = 0; b < 4; b++)
        begin
            load_word(32'(b) << 6);
            status(8'h80);
            settle(3);
            check("alarm brake", {31'h0, dynamic_brake}, 32'(!b[0]));
            status(8'h90);
            settle(3);
            check("alarm hold brake", {31'h0, dynamic_brake}, 32'(!b[0] && b[1]));
            status(8'h00);
            u_host.apply(5'b11001);
            u_host.apply(5'b11000);
        end
        for (int b = 0; b < 2; b++)
        begin
            load_word(32'(b) << 4);
            status(8'h20);
            settle(3);
            check("rotation running", {31'h0, rotation_detect_output}, 32'(!b));
            status(8'h08);
            settle(3);
            check("rotation torque", {31'h0, rotation_detect_output}, 32'(b));
        end
        for (int b = 0; b < 2; b++)
        begin
            load_word(32'(b) << 5);
            status(8'h50);
            status(8'h10);
            settle(3);
            bus(1'b0, sqs_pkg::OFS_SEQ_STATE, 32'h0);
            check("alarm after recovery", {31'h0, rd[7]}, 32'(!b));
            check("irq masked", {31'h0, irq}, 32'h0);
            bus(1'b1, sqs_pkg::OFS_IRQ_MASK, 32'h4);
            settle(2);
            check("irq raised", {31'h0, irq}, 32'h1);
            bus(1'b1, sqs_pkg::OFS_IRQ_STATUS, 32'hf);
            bus(1'b0, sqs_pkg::OFS_IRQ_STATUS, 32'h0);
            check("status cleared", rd, 32'h0);
            settle(2);
            check("irq cleared", {31'h0, irq}, 32'h0);
            bus(1'b1, sqs_pkg::OFS_IRQ_MASK, 32'h0);
            status(8'h00);
            u_host.apply(5'b11001);
            u_host.apply(5'b11000);
        end
        check("bus response", {31'h0, hresp}, 32'h0);
        tally_and_finish();
    end
endmodule

`default_nettype wire
